// *** common/wcs_pkg.sv ***
// constants and types of the watchdog and clock output source selection block
package wcs_pkg;

	// ----------------------------------------------------------------
	// register byte addresses
	// ----------------------------------------------------------------
	localparam logic [31:0] WCS_WDT_CHOICE_ADDR = 32'h400480d0;
	localparam logic [31:0] WCS_WDT_APPLY_ADDR  = 32'h400480d4;
	localparam logic [31:0] WCS_WDT_RATIO_ADDR  = 32'h400480d8;
	localparam logic [31:0] WCS_CKO_CHOICE_ADDR = 32'h400480e0;
	localparam logic [31:0] WCS_CKO_APPLY_ADDR  = 32'h400480e4;
	localparam logic [31:0] WCS_CKO_RATIO_ADDR  = 32'h400480e8;

	// ----------------------------------------------------------------
	// field layout and reset values
	// ----------------------------------------------------------------
	localparam int          WCS_CHOICE_W     = 2;
	localparam int          WCS_RATIO_W      = 8;
	localparam int          WCS_APPLY_BIT    = 0;
	localparam logic [1:0]  WCS_CHOICE_RST   = 2'h0;
	localparam logic        WCS_APPLY_RST    = 1'h0;
	localparam logic [7:0]  WCS_RATIO_RST    = 8'h00;
	localparam logic [7:0]  WCS_RATIO_OFF    = 8'h00;
	localparam logic [7:0]  WCS_RATIO_BYPASS = 8'h01;
	localparam logic [31:0] WCS_READ_NONE    = 32'h00000000;

	// ----------------------------------------------------------------
	// source levels vector: bit index per oscillator
	// ----------------------------------------------------------------
	localparam int          WCS_SRC_N    = 4;
	localparam int          WCS_SRC_IRC  = 0;
	localparam int          WCS_SRC_SYS  = 1;
	localparam int          WCS_SRC_WDO  = 2;
	localparam int          WCS_SRC_MAIN = 3;

	// selector codes
	localparam logic [1:0]  WCS_SEL_0 = 2'h0;
	localparam logic [1:0]  WCS_SEL_1 = 2'h1;
	localparam logic [1:0]  WCS_SEL_2 = 2'h2;
	localparam logic [1:0]  WCS_SEL_3 = 2'h3;

	// ----------------------------------------------------------------
	// state carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [WCS_CHOICE_W-1:0] choice;
		logic                    apply;
		logic [WCS_RATIO_W-1:0]  ratio;
		logic [WCS_CHOICE_W-1:0] applied;
		logic [WCS_CHOICE_W-1:0] target;
		logic                    pend;
		logic [WCS_RATIO_W-1:0]  cnt;
		logic                    out;
	} wcs_path_t;

	typedef struct packed {
		wcs_path_t              wdt;
		wcs_path_t              cko;
		logic [WCS_SRC_N-1:0]   prev;
		logic [31:0]            rdata;
		logic                   rerr;
	} wcs_state_t;

	localparam wcs_path_t  WCS_PATH_RST  = '{choice: WCS_CHOICE_RST, apply: WCS_APPLY_RST, ratio: WCS_RATIO_RST,
		applied: WCS_CHOICE_RST, target: WCS_CHOICE_RST, pend: 1'b0, cnt: 8'h00, out: 1'b0};
	localparam wcs_state_t WCS_STATE_RST = '{wdt: WCS_PATH_RST, cko: WCS_PATH_RST, prev: 4'h0,
		rdata: WCS_READ_NONE, rerr: 1'b0};

endpackage

// *** design/wcs_clock_select.sv ***
// watchdog clock and clock output source selection, division and apb registers
//
// Behaviour
// - the watchdog source selector picks rc oscillator (0), main clock (1), watchdog oscillator (2), 3 reserved, reset 0.
// - a new watchdog selection is applied only on a zero-to-one write of the watchdog apply bit, which resets to zero.
// - the watchdog clock is divided by the 8-bit ratio, zero stops it, and the ratio resets to zero.
// - the output selector picks rc oscillator (0), system oscillator (1), watchdog oscillator (2), main clock (3).
// - the output path switches source only on a zero-to-one write of the output apply bit.
// - the output clock is divided by the 8-bit ratio, zero disables it, and the ratio resets to zero.
// - the clock output pin carries the divided clock of the source currently applied on the output path.
`timescale 1ns/1ns
module wcs_clock_select (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [31:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic             PREADY,
	output logic      [31:0] PRDATA,
	output logic             PSLVERR,
	// oscillator levels, sampled on MCLK
	input  wire logic        INTERNAL_RC_OSC,
	input  wire logic        SYS_OSC,
	input  wire logic        WDT_OSC,
	input  wire logic        MAIN_CLK,
	// divided clocks
	output logic             WATCHDOG_TICK_CLOCK,
	output logic             CLOCK_OUT
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	wcs_pkg::wcs_state_t st_r;
	wcs_pkg::wcs_state_t st_nxt;

	logic [wcs_pkg::WCS_SRC_N-1:0] lvl;
	logic [wcs_pkg::WCS_SRC_N-1:0] rise;
	logic                          setup_ph;
	logic                          wr_acc;

	assign lvl      = {MAIN_CLK, WDT_OSC, SYS_OSC, INTERNAL_RC_OSC};
	assign rise     = lvl & ~st_r.prev;
	assign setup_ph = PSEL & ~PENABLE;
	assign wr_acc   = PSEL & PENABLE & PWRITE;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// pick one source bit; the two paths map codes differently
	function automatic logic pick(input logic is_wdt, input logic [1:0] sel, input logic [3:0] v);
		logic r;
		r = 1'b0;
		unique case (sel)
			wcs_pkg::WCS_SEL_0: r = v[wcs_pkg::WCS_SRC_IRC];
			wcs_pkg::WCS_SEL_1: r = is_wdt ? v[wcs_pkg::WCS_SRC_MAIN] : v[wcs_pkg::WCS_SRC_SYS];
			wcs_pkg::WCS_SEL_2: r = v[wcs_pkg::WCS_SRC_WDO];
			wcs_pkg::WCS_SEL_3: r = is_wdt ? 1'b0 : v[wcs_pkg::WCS_SRC_MAIN];
		endcase
		return r;
	endfunction

	// register writes of one path
	function automatic wcs_pkg::wcs_path_t reg_write(input wcs_pkg::wcs_path_t p, input logic hit_sel,
		input logic hit_apply, input logic hit_ratio, input logic [31:0] wd);
		wcs_pkg::wcs_path_t q;
		q = p;
		if (hit_sel) begin
			q.choice = wd[wcs_pkg::WCS_CHOICE_W-1:0];
		end
		if (hit_ratio) begin
			q.ratio = wd[wcs_pkg::WCS_RATIO_W-1:0];
		end
		if (hit_apply) begin
			q.apply = wd[wcs_pkg::WCS_APPLY_BIT];
			if (!p.apply && wd[wcs_pkg::WCS_APPLY_BIT]) begin
				q.target = p.choice;
				q.pend   = 1'b1;
			end
		end
		return q;
	endfunction

	// one clock step of a path: glitch-free switch, then divider
	function automatic wcs_pkg::wcs_path_t clk_step(input wcs_pkg::wcs_path_t p, input logic is_wdt,
		input logic [3:0] v, input logic [3:0] r);
		wcs_pkg::wcs_path_t q;
		logic               cur;
		logic               cur_rise;
		logic               nw;
		logic [8:0]         sum;
		logic [7:0]         half;
		logic [7:0]         cnt_n;
		q        = p;
		cur      = pick(is_wdt, p.applied, v);
		cur_rise = pick(is_wdt, p.applied, r);
		nw       = pick(is_wdt, p.target, v);
		sum      = {1'b0, p.ratio} + 9'h001;
		half     = sum[8:1];
		cnt_n    = 8'h00;
		if (p.pend && !p.out && !cur && !nw) begin
			q.applied = p.target;
			q.pend    = 1'b0;
			q.cnt     = 8'h00;
		end
		if (p.ratio == wcs_pkg::WCS_RATIO_OFF) begin
			q.out = 1'b0;
			q.cnt = 8'h00;
		end else if (p.ratio == wcs_pkg::WCS_RATIO_BYPASS) begin
			q.out = cur;
			q.cnt = 8'h00;
		end else if (cur_rise) begin
			// a shrunk ratio may leave cnt beyond the top; wrap then too
			if (p.cnt >= p.ratio - 8'h01) begin
				cnt_n = 8'h00;
			end else begin
				cnt_n = p.cnt + 8'h01;
			end
			q.cnt = cnt_n;
			q.out = (cnt_n < half);
		end
		return q;
	endfunction

	// read value at an address
	function automatic logic [31:0] rd_value(input wcs_pkg::wcs_state_t s, input logic [31:0] a);
		logic [31:0] d;
		d = wcs_pkg::WCS_READ_NONE;
		unique case (a)
			wcs_pkg::WCS_WDT_CHOICE_ADDR: d = {30'h0, s.wdt.choice};
			wcs_pkg::WCS_WDT_APPLY_ADDR:  d = {31'h0, s.wdt.apply};
			wcs_pkg::WCS_WDT_RATIO_ADDR:  d = {24'h0, s.wdt.ratio};
			wcs_pkg::WCS_CKO_CHOICE_ADDR: d = {30'h0, s.cko.choice};
			wcs_pkg::WCS_CKO_APPLY_ADDR:  d = {31'h0, s.cko.apply};
			wcs_pkg::WCS_CKO_RATIO_ADDR:  d = {24'h0, s.cko.ratio};
			default:                      d = wcs_pkg::WCS_READ_NONE;
		endcase
		return d;
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		return (a == wcs_pkg::WCS_WDT_CHOICE_ADDR) || (a == wcs_pkg::WCS_WDT_APPLY_ADDR)
			|| (a == wcs_pkg::WCS_WDT_RATIO_ADDR) || (a == wcs_pkg::WCS_CKO_CHOICE_ADDR)
			|| (a == wcs_pkg::WCS_CKO_APPLY_ADDR) || (a == wcs_pkg::WCS_CKO_RATIO_ADDR);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt      = st_r;
		st_nxt.prev = lvl;
		// clock paths step first, so a write this cycle lands on top
		st_nxt.wdt  = clk_step(st_r.wdt, 1'b1, lvl, rise);
		st_nxt.cko  = clk_step(st_r.cko, 1'b0, lvl, rise);
		if (wr_acc) begin
			st_nxt.wdt = reg_write(st_nxt.wdt, PADDR == wcs_pkg::WCS_WDT_CHOICE_ADDR,
				PADDR == wcs_pkg::WCS_WDT_APPLY_ADDR, PADDR == wcs_pkg::WCS_WDT_RATIO_ADDR, PWDATA);
			st_nxt.cko = reg_write(st_nxt.cko, PADDR == wcs_pkg::WCS_CKO_CHOICE_ADDR,
				PADDR == wcs_pkg::WCS_CKO_APPLY_ADDR, PADDR == wcs_pkg::WCS_CKO_RATIO_ADDR, PWDATA);
		end
		// read data and error captured in setup, held through access
		if (setup_ph) begin
			st_nxt.rdata = PWRITE ? wcs_pkg::WCS_READ_NONE : rd_value(st_r, PADDR);
			st_nxt.rerr  = ~mapped(PADDR);
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= wcs_pkg::WCS_STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// zero wait states: every access completes in its first access cycle
	assign PREADY  = 1'b1;
	assign PRDATA  = st_r.rdata;
	assign PSLVERR = st_r.rerr & PSEL & PENABLE;
	assign WATCHDOG_TICK_CLOCK = st_r.wdt.out;
	assign CLOCK_OUT = st_r.cko.out;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_wdt_irc_bypass;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.wdt.ratio == 8'h01 && st_r.wdt.applied == 2'h0 && !st_r.wdt.pend) |=>
			(WATCHDOG_TICK_CLOCK == $past(INTERNAL_RC_OSC));
	endproperty
	a_wdt_irc_bypass: assert property (p_wdt_irc_bypass) else $error("watchdog clock does not follow rc osc");

	property p_wdt_main_bypass;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.wdt.ratio == 8'h01 && st_r.wdt.applied == 2'h1 && !st_r.wdt.pend) |=>
			(WATCHDOG_TICK_CLOCK == $past(MAIN_CLK));
	endproperty
	a_wdt_main_bypass: assert property (p_wdt_main_bypass) else $error("watchdog clock misses main clock");

	property p_wdt_apply;
		@(posedge MCLK) disable iff (!RST_N)
		(wr_acc && PADDR == wcs_pkg::WCS_WDT_APPLY_ADDR && PWDATA[0] && !st_r.wdt.apply) |=>
			(st_r.wdt.pend && st_r.wdt.target == $past(st_r.wdt.choice));
	endproperty
	a_wdt_apply: assert property (p_wdt_apply) else $error("watchdog apply edge not taken");

	property p_wdt_no_apply;
		@(posedge MCLK) disable iff (!RST_N)
		(!st_r.wdt.pend && !(wr_acc && PADDR == wcs_pkg::WCS_WDT_APPLY_ADDR && PWDATA[0] && !st_r.wdt.apply)) |=>
			$stable(st_r.wdt.applied);
	endproperty
	a_wdt_no_apply: assert property (p_wdt_no_apply) else $error("watchdog source changed without apply edge");

	property p_wdt_off;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.wdt.ratio == 8'h00) [*2] |-> !WATCHDOG_TICK_CLOCK;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog clock runs with ratio zero");

	property p_cko_main_bypass;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.cko.ratio == 8'h01 && st_r.cko.applied == 2'h3 && !st_r.cko.pend) |=>
			(CLOCK_OUT == $past(MAIN_CLK));
	endproperty
	a_cko_main_bypass: assert property (p_cko_main_bypass) else $error("clock out does not follow main clock");

	property p_cko_apply;
		@(posedge MCLK) disable iff (!RST_N)
		(wr_acc && PADDR == wcs_pkg::WCS_CKO_APPLY_ADDR && PWDATA[0] && !st_r.cko.apply) |=>
			(st_r.cko.pend && st_r.cko.target == $past(st_r.cko.choice));
	endproperty
	a_cko_apply: assert property (p_cko_apply) else $error("clock out apply edge not taken");

	property p_cko_off;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.cko.ratio == 8'h00) ##1 (st_r.cko.ratio == 8'h00) |-> (CLOCK_OUT == 1'b0);
	endproperty
	a_cko_off: assert property (p_cko_off) else $error("clock out runs with ratio zero");

	property p_cko_div2;
		@(posedge MCLK) disable iff (!RST_N)
		(st_r.cko.ratio == 8'h02 && $past(st_r.cko.ratio) == 8'h02 && !st_r.cko.pend && $changed(CLOCK_OUT)) |->
			$past(pick(1'b0, st_r.cko.applied, rise));
	endproperty
	a_cko_div2: assert property (p_cko_div2) else $error("clock out toggled without a source edge");

	property p_cko_no_runt;
		@(posedge MCLK) disable iff (!RST_N)
		$changed(st_r.cko.applied) |-> (!CLOCK_OUT && !$past(CLOCK_OUT));
	endproperty
	a_cko_no_runt: assert property (p_cko_no_runt) else $error("clock out source switched while high");

	property p_rd_reserved;
		@(posedge MCLK) disable iff (!RST_N)
		(setup_ph && !PWRITE && PADDR == wcs_pkg::WCS_WDT_RATIO_ADDR) |=>
			(PRDATA[31:8] == 24'h0 && PRDATA[7:0] == $past(st_r.wdt.ratio) && !PSLVERR);
	endproperty
	a_rd_reserved: assert property (p_rd_reserved) else $error("ratio readback wrong or reserved bits set");

	property p_unmapped;
		@(posedge MCLK) disable iff (!RST_N)
		(setup_ph && !mapped(PADDR)) ##1 (PSEL && PENABLE) |-> (PSLVERR && PRDATA == 32'h0);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

endmodule

// *** sim/tb.sv ***
// self-checking bench of the watchdog and clock output source selection
`timescale 1ns/1ns
module tb;
	logic        mclk = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [3:0]  osc;
	logic        watchdog_tick_clock;
	logic        clkout;
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	localparam int HP [4] = '{2, 3, 4, 5};
	localparam logic [31:0] WC = wcs_pkg::WCS_WDT_CHOICE_ADDR;
	localparam logic [31:0] WA = wcs_pkg::WCS_WDT_APPLY_ADDR;
	localparam logic [31:0] WR = wcs_pkg::WCS_WDT_RATIO_ADDR;
	localparam logic [31:0] CC = wcs_pkg::WCS_CKO_CHOICE_ADDR;
	localparam logic [31:0] CA = wcs_pkg::WCS_CKO_APPLY_ADDR;
	localparam logic [31:0] CR = wcs_pkg::WCS_CKO_RATIO_ADDR;

	always #5 mclk = ~mclk;

	wcs_osc_model #(.H_IRC(HP[0]), .H_SYS(HP[1]), .H_WDO(HP[2]), .H_MAIN(HP[3])) u_osc (
		.MCLK(mclk), .LEVELS(osc));
	wcs_clock_select u_dut (
		.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
		.INTERNAL_RC_OSC(osc[0]), .SYS_OSC(osc[1]), .WDT_OSC(osc[2]), .MAIN_CLK(osc[3]),
		.WATCHDOG_TICK_CLOCK(watchdog_tick_clock), .CLOCK_OUT(clkout));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		@(posedge mclk);
		// no local wait limit: only the bench timeout ends a hung access
		while (pready !== 1'h1) begin
			@(posedge mclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        er;
		apb(1'h1, a, d, rd, er);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic eexp);
		logic [31:0] rd;
		logic        er;
		apb(1'h0, a, 32'h0, rd, er);
		check(rd, exp, "read data");
		check({31'h0, er}, {31'h0, eexp}, "slave error");
	endtask
	// zero then one, so the apply bit sees a fresh rising write
	task automatic upd(input logic [31:0] a);
		wr(a, 32'h0);
		wr(a, 32'h1);
	endtask
	// skips the first edge and times the second to the third, so a source change in flight is not timed
	task automatic meas(input logic wd, input int exp);
		logic l;
		logic p;
		int   n;
		int   e;
		int   t0;
		int   per;
		p = 1'h1;
		n = 0;
		e = 0;
		t0 = 0;
		per = 0;
		while (e < 3 && n < 8000) begin
			@(posedge mclk);
			#1;
			l = wd ? watchdog_tick_clock : clkout;
			if (l === 1'h1 && p === 1'h0) begin
				e++;
				per = n - t0;
				t0 = n;
			end
			p = l;
			n++;
		end
		@(posedge mclk);
		// fewer than three edges means the wait ran out
		check(32'(e), 32'h3, "clock edges seen");
		check(32'(per), 32'(exp), "clock period");
	endtask
	task automatic quiet(input logic wd, input int n);
		int hi;
		hi = 0;
		repeat (50) @(posedge mclk);
		repeat (n) begin
			@(posedge mclk);
			#1;
			if ((wd ? watchdog_tick_clock : clkout) !== 1'h0)
				hi++;
		end
		@(posedge mclk);
		check(32'(hi), 32'h0, "clock stopped");
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] regs [6] = '{WC, WA, WR, CC, CA, CR};
		foreach (regs[i]) rdchk(regs[i], 32'h0, 1'h0);
		check({31'h0, watchdog_tick_clock}, 32'h0, "watchdog clock idle");
		check({31'h0, clkout}, 32'h0, "output clock idle");
		$display("test reset done");
	endtask
	task automatic t_fields();
		wr(CC, 32'hffffffff);
		wr(CR, 32'hffffffff);
		wr(32'h400480dc, 32'hffffffff);
		rdchk(CC, 32'h3, 1'h0);
		rdchk(CR, 32'hff, 1'h0);
		rdchk(32'h400480dc, 32'h0, 1'h1);
		upd(CA);
		rdchk(CA, 32'h1, 1'h0);
		meas(1'h0, 255 * 2 * HP[3]);
		wr(CR, 32'h1);
		meas(1'h0, 2 * HP[3]);
		$display("test fields done");
	endtask
	task automatic t_sources();
		int wmap [3] = '{HP[0], HP[3], HP[2]};
		for (int s = 0; s < 3; s++) begin
			wr(WC, 32'(s));
			upd(WA);
			wr(WR, 32'(s + 1));
			meas(1'h1, (s + 1) * 2 * wmap[s]);
			wr(CR, 32'h2);
			wr(CC, 32'(s));
			upd(CA);
			meas(1'h0, 2 * 2 * HP[s]);
		end
		$display("test sources done");
	endtask
	task automatic t_hold();
		wr(CC, 32'h0);
		wr(CA, 32'h1);
		meas(1'h0, 2 * 2 * HP[2]);
		wr(CA, 32'h0);
		meas(1'h0, 2 * 2 * HP[2]);
		wr(CA, 32'h1);
		meas(1'h0, 2 * 2 * HP[0]);
		wr(CR, 32'h0);
		quiet(1'h0, 200);
		wr(WC, 32'h3);
		wr(WA, 32'h0);
		meas(1'h1, 3 * 2 * HP[2]);
		wr(WA, 32'h1);
		quiet(1'h1, 200);
		wr(WC, 32'h0);
		upd(WA);
		meas(1'h1, 3 * 2 * HP[0]);
		wr(WR, 32'h0);
		quiet(1'h1, 200);
		$display("test hold done");
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			$display("MISMATCH t=%0t timeout", $time);
			finish_test();
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'h1;
		@(posedge mclk);
		t_reset();
		t_fields();
		t_sources();
		t_hold();
		finish_test();
	end
endmodule

// *** sim/wcs_osc_model.sv ***
// oscillator sources seen by the clock select block
`timescale 1ns/1ns
module wcs_osc_model #(
	parameter int H_IRC  = 2,
	parameter int H_SYS  = 3,
	parameter int H_WDO  = 4,
	parameter int H_MAIN = 5
) (
	// clock
	input  wire logic       MCLK,
	// source levels, one bit per oscillator
	output logic      [3:0] LEVELS
);
	int         half [4] = '{H_IRC, H_SYS, H_WDO, H_MAIN};
	int         cnt  [4] = '{0, 0, 0, 0};
	logic [3:0] lv       = 4'h0;

	assign LEVELS = lv;
	// every source keeps running, so old and new are both live
	always @(posedge MCLK) begin
		for (int i = 0; i < 4; i++) begin
			if (cnt[i] >= half[i] - 1) begin
				cnt[i] <= 0;
				lv[i] <= ~lv[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule
